// file: common/smsp_pkg.sv
// constants, field positions and carrier types of the synchronous master serial port
// assumes an apb master with 32-bit data and byte addresses in paddr
package smsp_pkg;

  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TX_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RX_CTRL  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BAUD     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TX_BUF   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DIV_HIGH = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DIV_LOW  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 8'h20;

  // transmit_control_status fields
  localparam int TX_MASTER = 7;
  localparam int TX_NINE   = 6;
  localparam int TX_EN     = 5;
  localparam int TX_SYNC   = 4;
  localparam int TX_EMPTY  = 1;
  localparam int TX_NINTH  = 0;
  localparam logic [7:0] TX_WR_MASK = 8'hf1;

  // receive_control_status fields
  localparam int RX_PORT_EN = 7;
  localparam int RX_NINE    = 6;
  localparam int RX_SINGLE  = 5;
  localparam int RX_CONT    = 4;
  localparam int RX_FRAME   = 2;
  localparam int RX_OVERRUN = 1;
  localparam int RX_NINTH   = 0;
  localparam logic [7:0] RX_WR_MASK = 8'hf0;

  // baud_control fields
  localparam int BD_DATA_POL = 5;
  localparam int BD_CLK_POL  = 4;
  localparam int BD_WIDE     = 3;
  localparam logic [7:0] BD_WR_MASK = 8'h38;

  // flag and enable positions, shared by flags and enable registers
  localparam int FL_RX_DONE  = 5;
  localparam int FL_TX_EMPTY = 4;
  localparam logic [7:0] IE_WR_MASK = 8'h30;

  // reset values and last-bit indices
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [8:0] RST_SHIFT  = 9'h000;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;

  typedef enum logic [1:0] {
    SMSP_IDLE = 2'b00,
    SMSP_TX   = 2'b01,
    SMSP_RX   = 2'b10
  } smsp_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } smsp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } smsp_apb_rsp_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic sdat_o;
    logic sdat_oe;
  } smsp_pins_t;

endpackage : smsp_pkg

// file: src/smsp_top.sv
// synchronous master serial port: apb registers, baud divider, shifters, pin drive
// assumes ref_clk at 100 MHz and a serial peer that holds data around the sampling edge
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
module smsp_top (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // register bus
  input  wire smsp_pkg::smsp_apb_req_t apb_req,
  output smsp_pkg::smsp_apb_rsp_t   apb_rsp,
  // serial pins
  input  wire logic                 sdat_pin,
  output smsp_pkg::smsp_pins_t      pins,
  // interrupt request toward the processor
  output logic                      irq
);
  import smsp_pkg::*;

  function automatic logic [3:0] last_bit(input logic nine);
    last_bit = nine ? LAST_BIT_9 : LAST_BIT_8;
  endfunction : last_bit

  // software registers
  logic [7:0]  tx_ctrl_q;
  logic [7:0]  rx_ctrl_q;
  logic [7:0]  baud_q;
  logic [7:0]  div_hi_q;
  logic [7:0]  div_lo_q;
  logic [7:0]  ie_q;
  logic [7:0]  tbuf_q;
  logic        tbuf_full_q;
  logic [7:0]  rdata_q;
  logic        rx_ninth_q;
  logic        rx_flag_q;
  logic        overrun_q;
  // engine
  smsp_state_t state_q;
  smsp_state_t state_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic        phase_a_q;
  logic        phase_a_d;
  logic [16:0] hcnt_q;
  logic [16:0] hcnt_d;
  logic [8:0]  tsh_q;
  logic [8:0]  tsh_d;
  logic [8:0]  rsh_q;
  logic [8:0]  rsh_d;
  logic        take_buf;
  logic        rx_done;
  // bus answer
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  // pins
  logic        sclk_q;
  logic        sclk_oe_q;
  logic        sdat_q;
  logic        sdat_oe_q;
  logic        irq_q;

  // bus decode
  wire         acc      = apb_req.psel & apb_req.penable;
  wire         done_acc = acc & pready_q;
  wire         wr       = done_acc & apb_req.pwrite;
  wire         rd       = done_acc & ~apb_req.pwrite;
  wire [7:0]   wb       = apb_req.pwdata[7:0];
  wire         wr_tx    = wr & (apb_req.paddr == OFS_TX_CTRL);
  wire         wr_rx    = wr & (apb_req.paddr == OFS_RX_CTRL);
  wire         wr_baud  = wr & (apb_req.paddr == OFS_BAUD);
  wire         wr_tbuf  = wr & (apb_req.paddr == OFS_TX_BUF);
  wire         wr_hi    = wr & (apb_req.paddr == OFS_DIV_HIGH);
  wire         wr_lo    = wr & (apb_req.paddr == OFS_DIV_LOW);
  wire         wr_ie    = wr & (apb_req.paddr == OFS_IRQ_EN);
  wire         rd_rdata = rd & (apb_req.paddr == OFS_RX_DATA);

  // mode decode
  wire         mode_on  = rx_ctrl_q[RX_PORT_EN] & tx_ctrl_q[TX_SYNC]
                        & tx_ctrl_q[TX_MASTER];
  wire         tx_go    = mode_on & tx_ctrl_q[TX_EN] & tbuf_full_q;
  wire         rx_en    = rx_ctrl_q[RX_CONT] | rx_ctrl_q[RX_SINGLE];
  wire         clk_pol  = baud_q[BD_CLK_POL];
  wire         dat_pol  = baud_q[BD_DATA_POL];
  wire [15:0]  divisor  = baud_q[BD_WIDE] ? {div_hi_q, div_lo_q}
                                          : {8'h00, div_lo_q};
  // half a bit period lasts 2*(divisor+1) cycles
  wire [16:0]  half_end = {divisor, 1'b1};
  wire         tick     = (hcnt_q == half_end);
  wire         busy     = (state_q != SMSP_IDLE);
  wire         rx_bit   = sdat_pin ^ dat_pol;
  wire         tx_last  = (bit_q == last_bit(tx_ctrl_q[TX_NINE]));
  wire         rx_last  = (bit_q == last_bit(rx_ctrl_q[RX_NINE]));
  wire         tx_empty = ~tbuf_full_q;
  wire         sh_empty = (state_q != SMSP_TX);

  // read mux
  wire [7:0]   flags    = {2'b00, rx_flag_q, tx_empty, 4'h0};
  wire [7:0]   tx_rd    = {tx_ctrl_q[7:2], sh_empty, tx_ctrl_q[TX_NINTH]};
  wire [7:0]   rx_rd    = {rx_ctrl_q[7:4], 1'b0, 1'b0, overrun_q, rx_ninth_q};
  wire         hit      = (apb_req.paddr == OFS_TX_CTRL)  | (apb_req.paddr == OFS_RX_CTRL)
                        | (apb_req.paddr == OFS_BAUD)     | (apb_req.paddr == OFS_TX_BUF)
                        | (apb_req.paddr == OFS_RX_DATA)  | (apb_req.paddr == OFS_DIV_HIGH)
                        | (apb_req.paddr == OFS_DIV_LOW)  | (apb_req.paddr == OFS_FLAGS)
                        | (apb_req.paddr == OFS_IRQ_EN);
  wire [7:0]   rd_byte  = (apb_req.paddr == OFS_TX_CTRL)  ? tx_rd :
                          (apb_req.paddr == OFS_RX_CTRL)  ? rx_rd :
                          (apb_req.paddr == OFS_BAUD)     ? baud_q :
                          (apb_req.paddr == OFS_RX_DATA)  ? rdata_q :
                          (apb_req.paddr == OFS_DIV_HIGH) ? div_hi_q :
                          (apb_req.paddr == OFS_DIV_LOW)  ? div_lo_q :
                          (apb_req.paddr == OFS_FLAGS)    ? flags :
                          (apb_req.paddr == OFS_IRQ_EN)   ? ie_q : 8'h00;

  // pin levels: clock leaves idle in the first half of each bit
  wire         sclk_next = clk_pol ^ (busy & phase_a_q);
  wire         sdat_next = (state_q == SMSP_TX) ? (tsh_q[0] ^ dat_pol) : dat_pol;
  wire         sdat_drv  = mode_on & (state_q != SMSP_RX) & ~(rx_en & ~busy);
  wire         irq_next = (rx_flag_q & ie_q[FL_RX_DONE])
                        | (tx_empty & ie_q[FL_TX_EMPTY]);

  // serial engine
  always_comb begin
    state_d   = state_q;
    bit_d     = bit_q;
    phase_a_d = phase_a_q;
    hcnt_d    = hcnt_q;
    tsh_d     = tsh_q;
    rsh_d     = rsh_q;
    take_buf  = 1'b0;
    rx_done   = 1'b0;
    unique case (state_q)
      SMSP_IDLE: begin
        hcnt_d    = 17'h00000;
        bit_d     = 4'h0;
        phase_a_d = 1'b1;
        // transmit gets the turn first; a pending receive waits for the shifter
        if (tx_go) begin
          tsh_d    = {tx_ctrl_q[TX_NINTH], tbuf_q};
          take_buf = 1'b1;
          state_d  = SMSP_TX;
        end else if (mode_on & rx_en) begin
          state_d  = SMSP_RX;
        end
      end
      SMSP_TX, SMSP_RX: begin
        if (~mode_on | ((state_q == SMSP_RX) & ~rx_en)) begin
          state_d = SMSP_IDLE;
        end else if (!tick) begin
          hcnt_d = hcnt_q + 17'h00001;
        end else begin
          hcnt_d = 17'h00000;
          if (phase_a_q) begin
            phase_a_d = 1'b0;
            if (state_q == SMSP_RX) begin
              rsh_d = {rx_bit, rsh_q[8:1]};
            end
          end else begin
            phase_a_d = 1'b1;
            bit_d     = bit_q + 4'h1;
            if (state_q == SMSP_TX) begin
              tsh_d = {1'b0, tsh_q[8:1]};
              if (tx_last) begin
                bit_d = 4'h0;
                if (tx_go) begin
                  tsh_d    = {tx_ctrl_q[TX_NINTH], tbuf_q};
                  take_buf = 1'b1;
                end else begin
                  state_d = SMSP_IDLE;
                end
              end
            end else if (rx_last) begin
              bit_d   = 4'h0;
              rx_done = 1'b1;
              if (!rx_ctrl_q[RX_CONT]) begin
                state_d = SMSP_IDLE;
              end
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= SMSP_IDLE;
      bit_q     <= 4'h0;
      phase_a_q <= 1'b1;
      hcnt_q    <= 17'h00000;
      tsh_q     <= RST_SHIFT;
      rsh_q     <= RST_SHIFT;
    end else begin
      state_q   <= state_d;
      bit_q     <= bit_d;
      phase_a_q <= phase_a_d;
      hcnt_q    <= hcnt_d;
      tsh_q     <= tsh_d;
      rsh_q     <= rsh_d;
    end
  end

  // control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctrl_q <= RST_BYTE;
      baud_q    <= RST_BYTE;
      div_hi_q  <= RST_BYTE;
      div_lo_q  <= RST_BYTE;
      ie_q      <= RST_BYTE;
    end else begin
      if (wr_tx)   tx_ctrl_q <= wb & TX_WR_MASK;
      if (wr_baud) baud_q    <= wb & BD_WR_MASK;
      if (wr_hi)   div_hi_q  <= wb;
      if (wr_lo)   div_lo_q  <= wb;
      if (wr_ie)   ie_q      <= wb & IE_WR_MASK;
    end
  end

  // receive control: a software write wins over the automatic single-receive clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctrl_q <= RST_BYTE;
    end else if (wr_rx) begin
      rx_ctrl_q <= wb & RX_WR_MASK;
    end else if (rx_done & ~rx_ctrl_q[RX_CONT]) begin
      rx_ctrl_q[RX_SINGLE] <= 1'b0;
    end
  end

  // transmit buffer; a load into the shifter and a new write in one cycle keep the new word
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tbuf_q      <= RST_BYTE;
      tbuf_full_q <= 1'b0;
    end else if (wr_tbuf) begin
      tbuf_q      <= wb;
      tbuf_full_q <= 1'b1;
    end else if (take_buf) begin
      tbuf_full_q <= 1'b0;
    end
  end

  // receive data, ninth bit, completion flag and overrun
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q    <= RST_BYTE;
      rx_ninth_q <= 1'b0;
      rx_flag_q  <= 1'b0;
      overrun_q  <= 1'b0;
    end else begin
      if (rx_done) begin
        rdata_q    <= rx_ctrl_q[RX_NINE] ? rsh_q[7:0] : rsh_q[8:1];
        rx_ninth_q <= rx_ctrl_q[RX_NINE] & rsh_q[8];
        rx_flag_q  <= 1'b1;
      end else if (rd_rdata) begin
        rx_flag_q  <= 1'b0;
      end
      // an unread word overwritten is flagged; only clearing continuous mode clears it
      if (rx_done & rx_flag_q & ~rd_rdata) begin
        overrun_q <= 1'b1;
      end else if (~rx_ctrl_q[RX_CONT]) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // apb answer one cycle into the access phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc & ~pready_q;
      prdata_q  <= (acc & ~pready_q & ~apb_req.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
      pslverr_q <= acc & ~pready_q & ~hit;
    end
  end

  // pins and interrupt line, one cycle behind the engine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q    <= 1'b0;
      sclk_oe_q <= 1'b0;
      sdat_q    <= 1'b0;
      sdat_oe_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      sclk_q    <= sclk_next;
      sclk_oe_q <= mode_on;
      sdat_q    <= sdat_next;
      sdat_oe_q <= sdat_drv;
      irq_q     <= irq_next;
    end
  end

  assign apb_rsp.prdata  = prdata_q;
  assign apb_rsp.pready  = pready_q;
  assign apb_rsp.pslverr = pslverr_q;
  assign pins.sclk_o     = sclk_q;
  assign pins.sclk_oe    = sclk_oe_q;
  assign pins.sdat_o     = sdat_q;
  assign pins.sdat_oe    = sdat_oe_q;
  assign irq             = irq_q;

endmodule : smsp_top

// file: verif/smsp_top_asserts.sv
// port checks for the synchronous master serial port
// assumes an apb host that holds each request until pready
module smsp_top_asserts (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  // register bus
  input wire smsp_pkg::smsp_apb_req_t apb_req,
  input wire smsp_pkg::smsp_apb_rsp_t apb_rsp,
  // pins and interrupt
  input wire logic                    sdat_pin,
  input wire smsp_pkg::smsp_pins_t    pins,
  input wire logic                    irq
);
  import smsp_pkg::*;
  logic [7:0] txc_q, rxc_q, bd_q, ie_q;
  wire        wr_ok = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready;
  wire        mode  = txc_q[TX_MASTER] && txc_q[TX_SYNC] && rxc_q[RX_PORT_EN];
  wire        pol   = bd_q[BD_CLK_POL];
  // shadows of the control bytes so pin checks know the programmed mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {txc_q, rxc_q, bd_q, ie_q} <= '0;
    end else if (wr_ok) begin
      if (apb_req.paddr == OFS_TX_CTRL) txc_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == OFS_RX_CTRL) rxc_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == OFS_BAUD) bd_q <= apb_req.pwdata[7:0];
      if (apb_req.paddr == OFS_IRQ_EN) ie_q <= apb_req.pwdata[7:0] & IE_WR_MASK;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wait_s;
    apb_req.psel && apb_req.penable && !apb_rsp.pready;
  endsequence
  sequence answer_s;
    apb_rsp.pready ##1 !apb_rsp.pready;
  endsequence
  apb_wait_a: assert property (wait_s |=> answer_s) else $error("apb answer not one cycle");
  ready_cause_a: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
    else $error("stray pready");
  rdata_rest_a: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 32'h0)
    else $error("read data outside answer");
  err_zero_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
    else $error("bad error answer");
  map_ok_a: assert property (apb_rsp.pready && apb_req.paddr <= OFS_IRQ_EN
    && apb_req.paddr[1:0] == 2'b00 |-> !apb_rsp.pslverr) else $error("mapped address refused");
  mode_drive_a: assert property ($stable(mode) |-> pins.sclk_oe == mode)
    else $error("clock drive not following mode");
  clk_return_a: assert property (pins.sclk_oe && pins.sclk_o != pol |->
    ##[1:600] (pins.sclk_o == pol || !pins.sclk_oe)) else $error("clock stuck off idle");
  data_hold_a: assert property (pins.sdat_oe && $past(pins.sclk_oe)
    && $changed(pins.sclk_o) && pins.sclk_o == pol && pol == $past(pol, 2)
    |-> $stable(pins.sdat_o))
    else $error("data moved at sampling edge");
  irq_mask_a: assert property (ie_q == 8'h0 && $past(ie_q) == 8'h0 |-> !irq)
    else $error("irq while masked");
endmodule : smsp_top_asserts

bind smsp_top smsp_top_asserts i_smsp_top_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .sdat_pin(sdat_pin), .pins(pins), .irq(irq));

// file: verif/smsp_peer.sv
// serial slave peer: shifts in what the port sends, answers with a fixed word
// assumes the port pins and the bench share ref_clk
module smsp_peer (
  // clock, reset and setup
  input wire logic                 ref_clk,
  input wire logic                 rst_n,
  input wire logic                 clk_idle,
  input wire logic                 dat_idle,
  input wire logic [3:0]           wlen,
  input wire logic [8:0]           send,
  // port pins
  input wire smsp_pkg::smsp_pins_t pins,
  output logic                     sdat_line,
  // observation
  output logic [17:0]              got,
  output int                       nbits,
  output int                       per
);
  import smsp_pkg::*;
  logic sclk_prev_q;
  int   idx;
  int   cyc;
  wire  act   = pins.sclk_oe && pins.sclk_o != clk_idle;
  wire  trail = pins.sclk_oe && !act && sclk_prev_q != clk_idle;
  // released line shows the inverse of the last level, so no default can pass
  assign sdat_line = pins.sdat_oe ? pins.sdat_o
                   : act ? send[idx] ^ dat_idle : ~pins.sdat_o;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_q <= clk_idle;
      idx <= 0;
      cyc <= 0;
      got <= '0;
      nbits <= 0;
      per <= 0;
    end else begin
      sclk_prev_q <= pins.sclk_oe ? pins.sclk_o : clk_idle;
      cyc <= cyc + 1;
      if (act && sclk_prev_q == clk_idle) begin
        per <= cyc;
        cyc <= 1;
      end
      // sample where the clock returns to idle
      if (trail) begin
        got <= {pins.sdat_o ^ dat_idle, got[17:1]};
        nbits <= nbits + 1;
        idx <= (idx == int'(wlen) - 1) ? 0 : idx + 1;
      end
    end
  end
endmodule : smsp_peer

// file: verif/tb_top.sv
// bench: apb register sequences against the port and a serial peer
// assumes one apb wait state and a peer on the far side of the pins
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import smsp_pkg::*;
  logic          ref_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          peer_rst_n = 1'b0;
  smsp_apb_req_t apb_req = '0;
  smsp_apb_rsp_t apb_rsp;
  smsp_pins_t    pins;
  logic          sdat_pin, irq, err, n9, clk_idle = 1'b0, dat_idle = 1'b0;
  logic [3:0]    wlen = 4'h8;
  logic [8:0]    send = 9'h000;
  logic [17:0]   got;
  logic [31:0]   rd;
  logic [7:0]    w1, w2;
  int            nbits, per, fails = 0, num_checks = 0;
  always #5 ref_clk = ~ref_clk;
  smsp_top i_smsp_top (.ref_clk(ref_clk), .rst_n(rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .sdat_pin(sdat_pin), .pins(pins), .irq(irq));
  smsp_peer i_smsp_peer (.ref_clk(ref_clk), .rst_n(peer_rst_n), .clk_idle(clk_idle),
    .dat_idle(dat_idle), .wlen(wlen), .send(send), .pins(pins), .sdat_line(sdat_pin),
    .got(got), .nbits(nbits), .per(per));
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 9);
    if (apb_rsp.pready !== 1'b1) begin
      fails++;
      summarize();
    end
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge ref_clk);
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask : rdc
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n < 8000; n++) begin
      apb(1'b0, a, 32'h0);
      if ((rd & m) === v) break;
    end
    if (n == 8000) begin
      fails++;
      summarize();
    end
  endtask : poll
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    peer_rst_n <= 1'b1;
    @(posedge ref_clk);
    rdc(OFS_FLAGS, 32'hff, 32'h10);
    apb(1'b1, OFS_FLAGS, 32'h0);
    apb(1'b1, OFS_TX_CTRL, 32'h0);
    rdc(OFS_FLAGS, 32'hff, 32'h10);
    rdc(OFS_TX_CTRL, 32'h02, 32'h02);
    apb(1'b0, 8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'h10);
    @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    $display("test registers done");
    // bit rate, polarity, width and back-to-back words in four settings
    for (int i = 0; i < 4; i++) begin
      clk_idle <= i[0];
      dat_idle <= i[1];
      wlen <= i[1] ? 4'h9 : 4'h8;
      peer_rst_n <= 1'b0;
      n9 = ~i[0];
      w1 = 8'h5a + 8'(i);
      w2 = 8'hc3 - 8'(i);
      apb(1'b1, OFS_BAUD, {26'h0, i[1], i[0], i[0], 3'h0});
      apb(1'b1, OFS_DIV_HIGH, 32'h101);
      apb(1'b1, OFS_DIV_LOW, 32'h1);
      rdc(OFS_DIV_HIGH, 32'hffffffff, 32'h1);
      apb(1'b1, OFS_RX_CTRL, 32'h80);
      apb(1'b1, OFS_TX_CTRL, {24'h0, 1'b1, i[1], 2'b11, 3'h0, n9});
      peer_rst_n <= 1'b1;
      apb(1'b1, OFS_TX_BUF, {24'h0, w1});
      apb(1'b1, OFS_TX_BUF, {24'h0, w2});
      rdc(OFS_FLAGS, 32'h10, 32'h0);
      poll(OFS_TX_CTRL, 32'h02, 32'h02);
      rdc(OFS_FLAGS, 32'h10, 32'h10);
      chk({14'h0, got}, i[1] ? {14'h0, n9, w2, n9, w1} : {14'h0, w2, w1, 2'b0});
      chk(per, i[0] ? 32'd1032 : 32'd8);
      chk({29'h0, pins.sclk_oe, pins.sclk_o, pins.sdat_o},
          {30'h1, i[0], i[1]});
      $display("test transmit %0d done", i);
    end
    clk_idle <= 1'b0;
    dat_idle <= 1'b1;
    wlen <= 4'h9;
    send <= 9'h1a5;
    peer_rst_n <= 1'b0;
    apb(1'b1, OFS_BAUD, 32'h20);
    apb(1'b1, OFS_TX_CTRL, 32'h90);
    apb(1'b1, OFS_IRQ_EN, 32'h20);
    peer_rst_n <= 1'b1;
    apb(1'b1, OFS_RX_CTRL, 32'he0);
    @(posedge ref_clk);
    chk({31'h0, pins.sdat_oe}, 32'h0);
    poll(OFS_FLAGS, 32'h20, 32'h20);
    chk({31'h0, irq}, 32'h1);
    rdc(OFS_RX_CTRL, 32'h21, 32'h01);
    rdc(OFS_RX_DATA, 32'hff, 32'ha5);
    rdc(OFS_FLAGS, 32'h20, 32'h0);
    repeat (40) @(posedge ref_clk);
    chk(nbits, 32'd9);
    $display("test single receive done");
    send <= 9'h03c;
    wlen <= 4'h8;
    peer_rst_n <= 1'b0;
    @(posedge ref_clk);
    peer_rst_n <= 1'b1;
    apb(1'b1, OFS_RX_CTRL, 32'hb0);
    for (int k = 0; k < 2; k++) begin
      poll(OFS_FLAGS, 32'h20, 32'h20);
      rdc(OFS_RX_DATA, 32'hff, 32'h3c);
    end
    poll(OFS_RX_CTRL, 32'h02, 32'h02);
    apb(1'b1, OFS_RX_CTRL, 32'h80);
    rdc(OFS_RX_CTRL, 32'h12, 32'h0);
    $display("test continuous receive done");
    summarize();
  end
endmodule : tb_top
